// File: hdl/pcb_pkg.sv
// Purpose: shared constants for the config cycle generator, arbiter and slot agent
// Assumes: one bus clock shared by both ends
// Notes:   agent index 4 is the host bridge itself, it has no request pin
package pcb_pkg;
  // processor I/O ports
  localparam logic [15:0] CFG_ADDR_PORT  = 16'h0CF8;
  localparam logic [15:0] CFG_DATA_PORT  = 16'h0CFC;
  localparam logic [31:0] CFG_ADDR_RST   = 32'h0000_0000;
  // config address field positions
  localparam int          EN_BIT         = 31;
  localparam int          BUS_LSB        = 16;
  localparam int          DEV_LSB        = 11;
  localparam int          FUNC_LSB       = 8;
  localparam int          REG_LSB        = 2;
  localparam logic [1:0]  TYPE0          = 2'h0;
  localparam logic [1:0]  TYPE1          = 2'h1;
  // bus commands
  localparam logic [3:0]  CMD_CFG_RD     = 4'hA;
  localparam logic [3:0]  CMD_CFG_WR     = 4'hB;
  localparam logic [3:0]  CMD_MEM_RD     = 4'h6;
  localparam logic [3:0]  CMD_MEM_WR     = 4'h7;
  // slots: device number and chip select address line
  localparam int          NUM_SLOTS      = 4;
  localparam int          NUM_AGENTS     = 5;
  localparam int          HOST_AGENT     = 4;
  localparam logic [4:0]  SLOT_DEV  [NUM_SLOTS] = '{5'h04, 5'h09, 5'h0A, 5'h0B};
  localparam int          SLOT_LINE [NUM_SLOTS] = '{20, 25, 27, 29};
  localparam int          IDSEL_BASE     = 11;
  localparam int          IDSEL_TOP      = 31;
  // config space: 256 bytes, first 64 bytes the header
  localparam int          CFG_DWORDS     = 64;
  localparam int          HDR_DWORDS     = 16;
  // master abort when no target claims within this many cycles
  localparam int          ABORT_CYCLES   = 5;
  localparam logic [31:0] ALL_ONES       = 32'hFFFF_FFFF;
endpackage

// File: hdl/pcb_bus_if.sv
// Purpose: shared bus wires between host bridge and slot agents
// Assumes: undriven lines float high, as with pull-ups
// Notes:   each end drives its own out and enable; the levels are resolved here
`timescale 1ns/1ps
`default_nettype none
interface pcb_bus_if;
  // host bridge drive
  logic [31:0] h_ad_o;
  logic        h_ad_oe;
  logic [3:0]  h_cbe_o;
  logic        h_ctl_oe;
  logic        h_frame_n_o;
  logic        h_irdy_n_o;
  logic [3:0]  gnt_n;
  // slot agent drive, one entry per slot
  logic [31:0] a_ad_o      [pcb_pkg::NUM_SLOTS];
  logic        a_ad_oe     [pcb_pkg::NUM_SLOTS];
  logic [3:0]  a_cbe_o     [pcb_pkg::NUM_SLOTS];
  logic        a_ctl_oe    [pcb_pkg::NUM_SLOTS];
  logic        a_frame_n_o [pcb_pkg::NUM_SLOTS];
  logic        a_irdy_n_o  [pcb_pkg::NUM_SLOTS];
  logic        a_tgt_oe    [pcb_pkg::NUM_SLOTS];
  logic        a_trdy_n_o  [pcb_pkg::NUM_SLOTS];
  logic        a_devsel_n_o[pcb_pkg::NUM_SLOTS];
  logic [3:0]  req_n;
  // resolved levels
  logic [31:0] ad;
  logic [3:0]  cbe;
  logic        frame_n;
  logic        irdy_n;
  logic        trdy_n;
  logic        devsel_n;
  logic [3:0]  idsel;

  // wired-and of enabled drivers, high when nobody drives
  always_comb begin
    ad       = h_ad_oe  ? h_ad_o  : pcb_pkg::ALL_ONES;
    cbe      = h_ctl_oe ? h_cbe_o : 4'hF;
    frame_n  = h_ctl_oe ? h_frame_n_o : 1'b1;
    irdy_n   = h_ctl_oe ? h_irdy_n_o  : 1'b1;
    trdy_n   = 1'b1;
    devsel_n = 1'b1;
    for (int i = 0; i < pcb_pkg::NUM_SLOTS; i++) begin
      if (a_ad_oe[i]) ad = ad & a_ad_o[i];
      if (a_ctl_oe[i]) begin
        cbe     = cbe & a_cbe_o[i];
        frame_n = frame_n & a_frame_n_o[i];
        irdy_n  = irdy_n & a_irdy_n_o[i];
      end
      if (a_tgt_oe[i]) begin
        trdy_n   = trdy_n & a_trdy_n_o[i];
        devsel_n = devsel_n & a_devsel_n_o[i];
      end
    end
  end

  // each slot chip select is wired to one address line
  always_comb begin
    for (int i = 0; i < pcb_pkg::NUM_SLOTS; i++) idsel[i] = ad[pcb_pkg::SLOT_LINE[i]];
  end

  modport host  (output h_ad_o, h_ad_oe, h_cbe_o, h_ctl_oe, h_frame_n_o, h_irdy_n_o, gnt_n,
                 input  ad, frame_n, irdy_n, trdy_n, devsel_n, req_n);
  modport agent (output a_ad_o, a_ad_oe, a_cbe_o, a_ctl_oe, a_frame_n_o, a_irdy_n_o,
                        a_tgt_oe, a_trdy_n_o, a_devsel_n_o, req_n,
                 input  ad, cbe, frame_n, irdy_n, trdy_n, devsel_n, idsel, gnt_n);
endinterface
`default_nettype wire

// File: hdl/pcb_host_bridge.sv
// Purpose: config cycle generator behind the I/O ports plus round-robin bus arbiter
// Assumes: processor strobes are one-cycle pulses on the bus clock
// Notes:   the bridge is arbitration agent 4 and competes like any slot
`timescale 1ns/1ps
`default_nettype none
module pcb_host_bridge #(
  parameter logic [4:0] PARK_OK = 5'h1F  // agents allowed to hold a parked grant
) (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // processor I/O port
  input  wire logic [15:0] io_addr_i,
  input  wire logic        io_wr_i,
  input  wire logic        io_rd_i,
  input  wire logic [3:0]  io_be_i,
  input  wire logic [31:0] io_wdata_i,
  output logic [31:0]      io_rdata_o,
  output logic             io_ack_o,
  output logic             io_busy_o,
  // bus
  pcb_bus_if.host          bus
);
  typedef enum {ST_IDLE, ST_WAIT, ST_ADDR, ST_DATA, ST_TURN} pcb_host_st_t;

  pcb_host_st_t st_r;
  logic [31:0]  cfg_addr_r;
  logic [31:0]  wdata_r;
  logic [3:0]   be_r;
  logic         write_r;
  logic [31:0]  addr_phase;
  logic [31:0]  idsel_vec;
  logic [2:0]   wait_cnt_r;
  logic         host_req;
  logic [4:0]   req_vec;
  logic [2:0]   owner_r;
  logic         gnt_vld_r;
  logic         bus_free;
  logic         idle_prev_r;
  logic [2:0]   next_owner;
  logic         other_req;
  logic         cfg_ok;
  logic         data_hit;
  logic [4:0]   dev;

  assign dev      = cfg_addr_r[pcb_pkg::DEV_LSB +: 5];
  assign data_hit = (io_wr_i | io_rd_i) && io_addr_i == pcb_pkg::CFG_DATA_PORT;
  // only the two defined cycle types reach the bus
  assign cfg_ok   = cfg_addr_r[pcb_pkg::EN_BIT] &&
                    (cfg_addr_r[1:0] == pcb_pkg::TYPE0 || cfg_addr_r[1:0] == pcb_pkg::TYPE1);

  // one-hot chip select from the device number, all zero for device numbers above 20
  always_comb begin
    idsel_vec = 32'h0000_0000;
    if (dev <= 5'(pcb_pkg::IDSEL_TOP - pcb_pkg::IDSEL_BASE))
      idsel_vec[pcb_pkg::IDSEL_BASE + int'(dev)] = 1'b1;
    // slot lines are wired off the linear pattern, they take precedence
    for (int i = 0; i < pcb_pkg::NUM_SLOTS; i++) begin
      if (dev == pcb_pkg::SLOT_DEV[i]) begin
        idsel_vec = 32'h0000_0000;
        idsel_vec[pcb_pkg::SLOT_LINE[i]] = 1'b1;
      end
    end
  end

  // address phase contents
  always_comb begin
    if (cfg_addr_r[1:0] == pcb_pkg::TYPE1) begin
      // bus, device, function and index forwarded for a downstream bridge
      addr_phase = {8'h00, cfg_addr_r[23:2], pcb_pkg::TYPE1};
    end else begin
      // bus number left off the lines, chip select takes the upper bits
      addr_phase = {idsel_vec[31:11], cfg_addr_r[10:8], cfg_addr_r[7:2], pcb_pkg::TYPE0};
    end
  end

  // address register, 32-bit writes only, reserved bits kept zero
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_addr_r <= pcb_pkg::CFG_ADDR_RST;
    end else if (io_wr_i && io_addr_i == pcb_pkg::CFG_ADDR_PORT && io_be_i == 4'hF && st_r == ST_IDLE) begin
      cfg_addr_r <= {io_wdata_i[31], 7'h00, io_wdata_i[23:0]};
    end
  end

  // config access sequencer
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r       <= ST_IDLE;
      wdata_r    <= 32'h0000_0000;
      be_r       <= 4'h0;
      write_r    <= 1'b0;
      wait_cnt_r <= 3'h0;
      io_rdata_o <= 32'h0000_0000;
      io_ack_o   <= 1'b0;
    end else begin
      io_ack_o <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          if (data_hit && cfg_ok && io_be_i != 4'h0) begin
            // any non-empty mix of byte lanes allowed on the data port
            wdata_r <= io_wdata_i;
            be_r    <= io_be_i;
            write_r <= io_wr_i;
            st_r    <= ST_WAIT;
          end else if (data_hit) begin
            // disabled, undefined type or no byte lanes: no cycle, float-high data
            io_rdata_o <= pcb_pkg::ALL_ONES;
            io_ack_o   <= 1'b1;
          end else if (io_rd_i && io_addr_i == pcb_pkg::CFG_ADDR_PORT) begin
            io_rdata_o <= cfg_addr_r;
            io_ack_o   <= 1'b1;
          end else if (io_wr_i && io_addr_i == pcb_pkg::CFG_ADDR_PORT) begin
            io_ack_o <= 1'b1;
          end
        end
        ST_WAIT: begin
          if (gnt_vld_r && owner_r == 3'(pcb_pkg::HOST_AGENT) && bus_free) st_r <= ST_ADDR;
        end
        ST_ADDR: begin
          wait_cnt_r <= 3'h0;
          st_r       <= ST_DATA;
        end
        ST_DATA: begin
          wait_cnt_r <= wait_cnt_r + 3'h1;
          if (!bus.trdy_n) begin
            io_rdata_o <= bus.ad;
            io_ack_o   <= 1'b1;
            st_r       <= ST_TURN;
          end else if (bus.devsel_n && wait_cnt_r == 3'(pcb_pkg::ABORT_CYCLES - 1)) begin
            // nobody claimed: master abort, reads return all ones
            io_rdata_o <= pcb_pkg::ALL_ONES;
            io_ack_o   <= 1'b1;
            st_r       <= ST_TURN;
          end
        end
        ST_TURN: st_r <= ST_IDLE;
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  assign io_busy_o = st_r != ST_IDLE;
  assign host_req  = st_r == ST_WAIT;

  // bus drive: frame for the single address phase, irdy through the data phase
  always_comb begin
    bus.h_ctl_oe    = st_r == ST_ADDR || st_r == ST_DATA || st_r == ST_TURN;
    bus.h_frame_n_o = st_r != ST_ADDR;
    bus.h_irdy_n_o  = st_r != ST_DATA;
    bus.h_ad_oe     = st_r == ST_ADDR || (st_r == ST_DATA && write_r);
    bus.h_ad_o      = st_r == ST_ADDR ? addr_phase : wdata_r;
    bus.h_cbe_o     = st_r == ST_ADDR ? (write_r ? pcb_pkg::CMD_CFG_WR : pcb_pkg::CMD_CFG_RD) : ~be_r;
  end

  // slot k requests on pair k
  assign req_vec  = {host_req, ~bus.req_n};
  // free after one idle cycle, which leaves room for turnaround
  assign bus_free = bus.frame_n && bus.irdy_n && idle_prev_r;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) idle_prev_r <= 1'b0;
    else          idle_prev_r <= bus.frame_n && bus.irdy_n;
  end

  // round robin search starting after the current owner
  always_comb begin
    next_owner = owner_r;
    other_req  = 1'b0;
    for (int i = pcb_pkg::NUM_AGENTS - 1; i >= 1; i--) begin
      if (req_vec[(int'(owner_r) + i) % pcb_pkg::NUM_AGENTS]) begin
        next_owner = 3'((int'(owner_r) + i) % pcb_pkg::NUM_AGENTS);
        other_req  = 1'b1;
      end
    end
  end

  // grant holder and validity
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      owner_r   <= 3'(pcb_pkg::HOST_AGENT);
      gnt_vld_r <= 1'b0;
    end else if (bus_free) begin
      if (other_req && gnt_vld_r) begin
        // take the old grant away before handing out a new one
        gnt_vld_r <= 1'b0;
      end else if (other_req) begin
        owner_r   <= next_owner;
        gnt_vld_r <= 1'b1;
      end else if (req_vec[owner_r]) begin
        gnt_vld_r <= 1'b1;
      end else if (!PARK_OK[owner_r]) begin
        // agents barred from parking lose the grant once idle
        gnt_vld_r <= 1'b0;
      end
      // otherwise the grant stays parked on the owner
    end
  end

  // grant pins, active low, one at most
  always_comb begin
    for (int i = 0; i < pcb_pkg::NUM_SLOTS; i++)
      bus.gnt_n[i] = !(gnt_vld_r && owner_r == 3'(i));
  end
endmodule
`default_nettype wire

// File: hdl/pcb_slot_agent.sv
// Purpose: one expansion slot: single-phase bus master and config target
// Assumes: target answers configuration cycles only, one data phase each
// Notes:   instantiate once per slot with SLOT set to its pair number
`timescale 1ns/1ps
`default_nettype none
module pcb_slot_agent #(
  parameter int          SLOT   = 0,
  parameter logic [31:0] ID_VAL = 32'h1234_5678  // identity word, value arbitrary
) (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // user master request
  input  wire logic        usr_go_i,
  input  wire logic        usr_write_i,
  input  wire logic [31:0] usr_addr_i,
  input  wire logic [31:0] usr_wdata_i,
  output logic             usr_done_o,
  output logic [31:0]      usr_rdata_o,
  // bus
  pcb_bus_if.agent         bus
);
  typedef enum {MS_IDLE, MS_REQ, MS_ADDR, MS_DATA, MS_TURN} pcb_mst_st_t;

  pcb_mst_st_t mst_r;
  logic [31:0] addr_r;
  logic [31:0] wdata_r;
  logic        write_r;
  logic [2:0]  wait_r;
  logic        idle_prev_r;
  logic        mine;
  logic        tgt_r;
  logic        tgt_wr_r;
  logic [5:0]  tgt_idx_r;
  logic [31:0] space_r [pcb_pkg::CFG_DWORDS];
  logic        cfg_hit;

  assign mine = !bus.gnt_n[SLOT] && bus.frame_n && bus.irdy_n && idle_prev_r;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) idle_prev_r <= 1'b0;
    else          idle_prev_r <= bus.frame_n && bus.irdy_n;
  end

  // master side
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mst_r       <= MS_IDLE;
      addr_r      <= 32'h0000_0000;
      wdata_r     <= 32'h0000_0000;
      write_r     <= 1'b0;
      wait_r      <= 3'h0;
      usr_done_o  <= 1'b0;
      usr_rdata_o <= 32'h0000_0000;
    end else begin
      usr_done_o <= 1'b0;
      case (mst_r)
        MS_IDLE: if (usr_go_i) begin
          addr_r  <= usr_addr_i;
          wdata_r <= usr_wdata_i;
          write_r <= usr_write_i;
          // parked owner skips the request
          mst_r   <= mine ? MS_ADDR : MS_REQ;
        end
        MS_REQ:  if (mine) mst_r <= MS_ADDR;
        MS_ADDR: begin
          wait_r <= 3'h0;
          mst_r  <= MS_DATA;
        end
        MS_DATA: begin
          wait_r <= wait_r + 3'h1;
          if (!bus.trdy_n || (bus.devsel_n && wait_r == 3'(pcb_pkg::ABORT_CYCLES - 1))) begin
            usr_rdata_o <= bus.trdy_n ? pcb_pkg::ALL_ONES : bus.ad;
            usr_done_o  <= 1'b1;
            mst_r       <= MS_TURN;
          end
        end
        MS_TURN: mst_r <= MS_IDLE;
        default: mst_r <= MS_IDLE;
      endcase
    end
  end

  assign bus.req_n[SLOT] = mst_r != MS_REQ;

  // master drive: frame and address after the grant
  always_comb begin
    bus.a_ctl_oe[SLOT]    = mst_r == MS_ADDR || mst_r == MS_DATA || mst_r == MS_TURN;
    bus.a_frame_n_o[SLOT] = mst_r != MS_ADDR;
    bus.a_irdy_n_o[SLOT]  = mst_r != MS_DATA;
    bus.a_cbe_o[SLOT]     = mst_r == MS_ADDR ? (write_r ? pcb_pkg::CMD_MEM_WR : pcb_pkg::CMD_MEM_RD) : 4'h0;
    bus.a_ad_oe[SLOT]     = mst_r == MS_ADDR || (mst_r == MS_DATA && write_r) || (tgt_r && !tgt_wr_r);
    bus.a_ad_o[SLOT]      = mst_r == MS_ADDR ? addr_r : (mst_r == MS_DATA ? wdata_r : space_r[tgt_idx_r]);
  end

  // target: claim Type 0 config cycles carrying our chip select
  assign cfg_hit = !bus.frame_n && bus.idsel[SLOT] && bus.ad[1:0] == pcb_pkg::TYPE0 &&
                   (bus.cbe == pcb_pkg::CMD_CFG_RD || bus.cbe == pcb_pkg::CMD_CFG_WR);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tgt_r     <= 1'b0;
      tgt_wr_r  <= 1'b0;
      tgt_idx_r <= 6'h00;
    end else if (cfg_hit) begin
      tgt_r     <= 1'b1;
      tgt_wr_r  <= bus.cbe == pcb_pkg::CMD_CFG_WR;
      tgt_idx_r <= bus.ad[7:2];
    end else if (tgt_r && !bus.irdy_n) begin
      tgt_r <= 1'b0;
    end
  end

  // config space: 64 dwords, word 0 holds the read-only identity
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < pcb_pkg::CFG_DWORDS; i++) space_r[i] <= 32'h0000_0000;
    end else begin
      space_r[0] <= ID_VAL;
      if (tgt_r && tgt_wr_r && !bus.irdy_n && tgt_idx_r != 6'h00) begin
        for (int b = 0; b < 4; b++)
          if (!bus.cbe[b]) space_r[tgt_idx_r][8*b +: 8] <= bus.ad[8*b +: 8];
      end
    end
  end

  assign bus.a_tgt_oe[SLOT]     = tgt_r;
  assign bus.a_devsel_n_o[SLOT] = !tgt_r;
  assign bus.a_trdy_n_o[SLOT]   = !(tgt_r && !bus.irdy_n);
endmodule
`default_nettype wire

// File: test/pcb_bus_properties.sv
// Purpose: bus-level checks between the host bridge and the slot agents
// Assumes: one bus clock, asynchronous active-low reset
// Notes:   sees only the resolved interface lines, so host-side strobes are out of view
`timescale 1ns/1ps
`default_nettype none
module pcb_bus_properties (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // arbitration pairs
  input  wire logic [3:0]  gnt_n_i,
  input  wire logic [3:0]  req_n_i,
  // shared lines
  input  wire logic [31:0] ad_i,
  input  wire logic [3:0]  cbe_i,
  input  wire logic        frame_n_i,
  input  wire logic        irdy_n_i,
  input  wire logic        devsel_n_i,
  input  wire logic [3:0]  idsel_i
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  logic frame_q_r;
  logic adr_ph;
  logic cfg_adr;
  logic mem_adr;

  // frame history, so the address phase is seen without sampled-value calls here
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      frame_q_r <= 1'b1;
    end else begin
      frame_q_r <= frame_n_i;
    end
  end

  // address phase by command class
  assign adr_ph  = frame_q_r && !frame_n_i;
  assign cfg_adr = adr_ph && (cbe_i == pcb_pkg::CMD_CFG_RD || cbe_i == pcb_pkg::CMD_CFG_WR);
  assign mem_adr = adr_ph && (cbe_i == pcb_pkg::CMD_MEM_RD || cbe_i == pcb_pkg::CMD_MEM_WR);

  a_one_grant_max: assert property ($onehot0(~gnt_n_i))
    else $error("more than one grant asserted");
  a_grant_at_idle: assert property ($changed(gnt_n_i) |-> $past(frame_n_i) && $past(irdy_n_i))
    else $error("grant moved while bus busy");
  a_drop_before_switch: assert property (gnt_n_i != 4'hF && $past(gnt_n_i) != 4'hF
                                         |-> gnt_n_i == $past(gnt_n_i))
    else $error("grant switched without idle cycle");
  a_cfg_type_legal: assert property (cfg_adr |-> ad_i[1:0] == pcb_pkg::TYPE0 || ad_i[1:0] == pcb_pkg::TYPE1)
    else $error("config cycle with bad type bits");
  a_type0_one_line: assert property (cfg_adr && ad_i[1:0] == pcb_pkg::TYPE0 |-> $onehot0(ad_i[31:11]))
    else $error("type 0 drives several select lines");
  a_type1_bus_top: assert property (cfg_adr && ad_i[1:0] == pcb_pkg::TYPE1 |-> ad_i[31:24] == 8'h00)
    else $error("type 1 upper byte not zero");
  a_slot_claims: assert property (cfg_adr && ad_i[1:0] == pcb_pkg::TYPE0 && |idsel_i && ad_i[10:8] == 3'h0
                                  |-> ##[1:2] !devsel_n_i)
    else $error("selected slot did not claim");
  a_master_granted: assert property (mem_adr |-> $past(gnt_n_i) != 4'hF)
    else $error("master started without grant");
  for (genvar k = 0; k < 4; k++) begin : g_req
    a_req_to_grant: assert property ($fell(req_n_i[k]) |-> ##[1:100] !gnt_n_i[k])
      else $error("request not granted in time");
  end
endmodule
`default_nettype wire

// File: test/pci_config_cycle_and_arbiter_tb.sv
// Purpose: host bridge and four slot agents joined on one bus, driven by port tasks
// Assumes: nothing claims memory cycles, so slot transfers end in master abort
// Notes:   identity words of the slots are arbitrary values
`timescale 1ns/1ps
`default_nettype none
module pci_config_cycle_and_arbiter_tb;
  localparam int          TMO     = 8000;
  localparam logic [31:0] ID_BASE = 32'hC0DE_0000;  // arbitrary identity base
  logic        clock_i  = 1'b0;
  logic        rst_n_i  = 1'b0;
  logic [15:0] io_addr  = 16'h0000;
  logic        io_wr    = 1'b0;
  logic        io_rd    = 1'b0;
  logic [3:0]  io_be    = 4'h0;
  logic [31:0] io_wdata = 32'h0000_0000;
  logic [31:0] io_rdata;
  logic        io_ack;
  logic        io_busy;
  logic        busy_ack = 1'b0;
  logic [31:0] adr_seen = 32'h0000_0000;
  logic [3:0]  go       = 4'h0;
  logic [3:0]  done;
  logic        watch    = 1'b0;
  logic        saw      = 1'b0;
  int          own      = 0;
  int          q[$];
  int          n_errors = 0;
  int          checks   = 0;
  int          cyc      = 0;

  pcb_bus_if bus ();

  pcb_host_bridge pcb_host_bridge_i (
    .clock_i    (clock_i),
    .rst_n_i    (rst_n_i),
    .io_addr_i  (io_addr),
    .io_wr_i    (io_wr),
    .io_rd_i    (io_rd),
    .io_be_i    (io_be),
    .io_wdata_i (io_wdata),
    .io_rdata_o (io_rdata),
    .io_ack_o   (io_ack),
    .io_busy_o  (io_busy),
    .bus        (bus)
  );

  // slot k sits on request/grant pair k
  for (genvar k = 0; k < 4; k++) begin : g_slot
    pcb_slot_agent #(.SLOT(k), .ID_VAL(ID_BASE + k)) pcb_slot_agent_i (
      .clock_i     (clock_i),
      .rst_n_i     (rst_n_i),
      .usr_go_i    (go[k]),
      .usr_write_i (1'b1),
      .usr_addr_i  (32'h4000_0000 + k),
      .usr_wdata_i (ID_BASE),
      .usr_done_o  (done[k]),
      .usr_rdata_o (),
      .bus         (bus)
    );
  end

  pcb_bus_properties pcb_bus_properties_i (
    .clock_i  (clock_i),
    .rst_n_i  (rst_n_i),
    .gnt_n_i    (bus.gnt_n),
    .req_n_i    (bus.req_n),
    .ad_i       (bus.ad),
    .cbe_i      (bus.cbe),
    .frame_n_i  (bus.frame_n),
    .irdy_n_i   (bus.irdy_n),
    .devsel_n_i (bus.devsel_n),
    .idsel_i    (bus.idsel)
  );

  // free-running bus clock
  always #5 clock_i = ~clock_i;

  // completion order and request watch; reads pre-edge values, so no race with the design
  always @(posedge clock_i) begin
    for (int k = 0; k < 4; k++) begin
      if (done[k] === 1'b1) q.push_back(k);
    end
    if (watch && bus.req_n[own] === 1'b0) saw <= 1'b1;
    if (bus.frame_n === 1'b0) adr_seen <= bus.ad;  // last address phase on the lines
  end

  // hang guard
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == TMO) begin
      n_errors++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // one processor port access, strobed for one cycle, then wait for the answer
  task automatic io_acc(input logic wr, input logic [15:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clock_i);
    io_wr    <= wr;
    io_rd    <= !wr;
    io_addr  <= a;
    io_be    <= be;
    io_wdata <= d;
    @(posedge clock_i);
    io_wr <= 1'b0;
    io_rd <= 1'b0;
    repeat (200) begin
      @(negedge clock_i);
      if (io_ack === 1'b1) break;
    end
    busy_ack = io_busy;
    check({31'h0, io_ack}, 32'h1);
  endtask

  task automatic cfg_wr(input logic [31:0] adr, input logic [3:0] be, input logic [31:0] d);
    io_acc(1'b1, pcb_pkg::CFG_ADDR_PORT, 4'hF, adr);
    io_acc(1'b1, pcb_pkg::CFG_DATA_PORT, be, d);
  endtask

  task automatic cfg_rd(input logic [31:0] adr, input logic [3:0] be, input logic [31:0] exp);
    io_acc(1'b1, pcb_pkg::CFG_ADDR_PORT, 4'hF, adr);
    io_acc(1'b0, pcb_pkg::CFG_DATA_PORT, be, 32'h0000_0000);
    check(io_rdata, exp);
  endtask

  task automatic wait_q(input int n);
    repeat (400) begin
      @(negedge clock_i);
      if (q.size() >= n) break;
    end
    check(q.size(), n);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    logic [31:0] base;
    logic [31:0] bad [4];
    bad = '{32'h0000_2000, 32'h8000_2002, 32'h8000_2003, 32'h8000_2000};
    repeat (6) @(posedge clock_i);
    rst_n_i <= 1'b1;
    io_acc(1'b0, pcb_pkg::CFG_ADDR_PORT, 4'hF, 32'h0);
    check(io_rdata, pcb_pkg::CFG_ADDR_RST);
    io_acc(1'b1, pcb_pkg::CFG_ADDR_PORT, 4'hF, 32'hFF00_5A04);
    io_acc(1'b1, pcb_pkg::CFG_ADDR_PORT, 4'h3, 32'h0000_0000);
    io_acc(1'b0, pcb_pkg::CFG_ADDR_PORT, 4'hF, 32'h0);
    check(io_rdata, 32'h8000_5A04);
    for (int k = 0; k < 4; k++) begin
      base = {1'b1, 15'h0000, pcb_pkg::SLOT_DEV[k], 11'h000};
      cfg_rd(base, 4'hF, ID_BASE + k);
      check(adr_seen, 32'h1 << pcb_pkg::SLOT_LINE[k]);
      check({31'h0, busy_ack}, 32'h1);
      cfg_wr(base, 4'hF, ~ID_BASE);
      cfg_rd(base, 4'hF, ID_BASE + k);
      cfg_wr(base | ((k + 5) << 2), 4'hF, 32'hA5A5_0000 + k);
      cfg_rd(base | ((k + 5) << 2), 4'hF, 32'hA5A5_0000 + k);
      check(adr_seen, (32'h1 << pcb_pkg::SLOT_LINE[k]) | ((k + 5) << 2));
      cfg_wr(base | 32'hFC, 4'hF, 32'hAABB_CCDD);
      cfg_wr(base | 32'hFC, 4'h3, 32'h1111_2222);
      cfg_wr(base | 32'hFC, 4'h4, 32'h0033_0000);
      cfg_rd(base | 32'hFC, 4'hF, 32'hAA33_2222);
    end
    cfg_rd(32'h8000_1800, 4'hF, pcb_pkg::ALL_ONES);
    check(adr_seen, 32'h1 << (pcb_pkg::IDSEL_BASE + 3));
    check({31'h0, busy_ack}, 32'h1);
    cfg_rd(32'h8008_2001, 4'hF, pcb_pkg::ALL_ONES);
    check(adr_seen, 32'h0008_2001);
    for (int i = 0; i < 4; i++) begin
      cfg_rd(bad[i], (i == 3) ? 4'h0 : 4'hF, pcb_pkg::ALL_ONES);
      check({31'h0, busy_ack}, 32'h0);
    end
    // all four slots compete from the same edge
    q.delete();
    @(posedge clock_i);
    go <= 4'hF;
    @(posedge clock_i);
    go <= 4'h0;
    wait_q(4);
    for (int i = 0; i < 3; i++) begin
      check(q[i + 1], (q[i] + 1) % 4);
    end
    own = q[3];
    repeat (4) @(posedge clock_i);
    check({28'h0, bus.gnt_n}, {28'h0, ~(4'h1 << own)});
    // parked owner starts again without raising its request
    watch <= 1'b1;
    @(posedge clock_i);
    go[own] <= 1'b1;
    @(posedge clock_i);
    go[own] <= 1'b0;
    wait_q(5);
    check({31'h0, saw}, 32'h0);
    check(q[4], own);
    check(adr_seen, 32'h4000_0000 + own);
    cfg_rd({1'b1, 15'h0000, pcb_pkg::SLOT_DEV[0], 11'h000}, 4'hF, ID_BASE);
    tally_and_finish();
  end
endmodule
`default_nettype wire
